//--- rtl/pcs_synth_ctrl.sv
// Purpose: digital control of a clock synthesizer: dividers, switchover
// Assumes: reference and feedback inputs are levels synchronous to clock
// Notes: i_ref_clk stands in for the oscillator the post-scalers divide
`timescale 1ns/1ps
`default_nettype none
module pcs_synth_ctrl
  import pcs_pkg::*;
#(
  parameter int LOSS_LIMIT = pcs_pkg::LOSS_CYCLES
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_reference_clock_input_pri,
  input wire logic i_reference_clock_input_sec,
  input wire logic i_feedback_clock_input,
  input wire logic [pcs_pkg::NM_W-1:0] i_pre_div,
  input wire logic [pcs_pkg::NM_W-1:0] i_mult,
  input wire logic [pcs_pkg::NUM_POST-1:0][pcs_pkg::POST_W-1:0] i_post_div,
  input wire logic [pcs_pkg::NUM_POST-1:0] i_post_duty50,
  input wire logic [pcs_pkg::NUM_POST-1:0][pcs_pkg::POST_W-1:0] i_post_high,
  input wire logic [pcs_pkg::NUM_EXT_PINS-1:0][pcs_pkg::EXT_SEL_W-1:0]
    i_ext_sel,
  input wire logic [pcs_pkg::NUM_EXT_PINS-1:0] i_ext_invert,
  input wire logic i_ext_user_mode,
  input wire logic [pcs_pkg::NUM_EXT_PINS-1:0] i_ext_user_data,
  output logic o_osc_up,
  output logic o_osc_dn,
  output logic o_ref_on_secondary,
  output logic [pcs_pkg::NUM_REGIONAL-1:0] o_regional_clk,
  output logic [pcs_pkg::NUM_GLOBAL-1:0] o_global_clk,
  output logic [pcs_pkg::NUM_EXTERNAL-1:0] o_ext_cnt_clk,
  output logic [pcs_pkg::NUM_EXT_PINS-1:0] o_external_clock_output
);
  logic pri_prev_q;
  logic sec_prev_q;
  logic fb_prev_q;
  logic pri_rise;
  logic ref_rise;
  logic fb_rise;
  logic [POST_W-1:0] n_eff;
  logic [POST_W-1:0] m_eff;
  logic [POST_W-1:0] pre_cnt_q;
  logic [POST_W-1:0] fb_cnt_q;
  logic ref_evt;
  logic fb_evt;
  logic up_q;
  logic dn_q;
  logic on_sec_q;
  logic [LOSS_W-1:0] loss_cnt_q;
  logic [NUM_POST-1:0] post_clk;
  logic [NUM_EXT_PINS-1:0] pin_q;

  // edge history of the sampled inputs
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pri_prev_q <= 1'b0;
      sec_prev_q <= 1'b0;
      fb_prev_q <= 1'b0;
    end
    else
    begin
      pri_prev_q <= i_reference_clock_input_pri;
      sec_prev_q <= i_reference_clock_input_sec;
      fb_prev_q <= i_feedback_clock_input;
    end
  end

  // per-input edges avoid a false edge when the mux flips
  assign pri_rise = i_reference_clock_input_pri & ~pri_prev_q;
  assign ref_rise = on_sec_q ? (i_reference_clock_input_sec & ~sec_prev_q)
                             : pri_rise;
  assign fb_rise = i_feedback_clock_input & ~fb_prev_q;
  assign n_eff = pcs_sat({1'b0, i_pre_div}, NM_MAX);
  assign m_eff = pcs_sat({1'b0, i_mult}, NM_MAX);
  assign ref_evt = ref_rise && (pre_cnt_q >= n_eff - 11'h001);
  assign fb_evt = fb_rise && (fb_cnt_q >= m_eff - 11'h001);

  // pre-scale divider on the selected reference
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      pre_cnt_q <= 11'h000;
    else if (ref_evt)
      pre_cnt_q <= 11'h000;
    else if (ref_rise)
      pre_cnt_q <= pre_cnt_q + 11'h001;
  end

  // multiply counter divides the feedback clock
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      fb_cnt_q <= 11'h000;
    else if (fb_evt)
      fb_cnt_q <= 11'h000;
    else if (fb_rise)
      fb_cnt_q <= fb_cnt_q + 11'h001;
  end

  // frequency detector: coincident events cancel, no correction
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end
    else
    begin
      up_q <= ref_evt & ~fb_evt;
      dn_q <= fb_evt & ~ref_evt;
    end
  end

  // clock sense; sticky until reset so a flaky primary cannot bounce
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      loss_cnt_q <= '0;
      on_sec_q <= 1'b0;
    end
    else if (pri_rise)
      loss_cnt_q <= '0;
    else if (loss_cnt_q >= LOSS_W'(LOSS_LIMIT - 1))
      on_sec_q <= 1'b1;
    else
      loss_cnt_q <= loss_cnt_q + 1'b1;
  end

  // ten independent post-scale counters off the oscillator
  for (genvar k = 0; k < NUM_POST; k++)
  begin : g_post
    pcs_post_div u_post (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_div(i_post_div[k]),
      .i_duty50(i_post_duty50[k]),
      .i_high(i_post_high[k]),
      .o_clk(post_clk[k])
    );
  end

  // external pins: counter select, polarity, or plain user data
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      pin_q <= '0;
    else
      for (int p = 0; p < NUM_EXT_PINS; p++)
        if (i_ext_user_mode)
          pin_q[p] <= i_ext_user_data[p];
        else
          pin_q[p] <= post_clk[EXT_BASE + int'(i_ext_sel[p])]
                      ^ i_ext_invert[p];
  end

  assign o_osc_up = up_q;
  assign o_osc_dn = dn_q;
  assign o_ref_on_secondary = on_sec_q;
  assign o_regional_clk = post_clk[GLOBAL_BASE-1:0];
  assign o_global_clk = post_clk[EXT_BASE-1:GLOBAL_BASE];
  assign o_ext_cnt_clk = post_clk[NUM_POST-1:EXT_BASE];
  assign o_external_clock_output = pin_q;

  nm_range_a: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    pre_cnt_q < NM_MAX && fb_cnt_q < NM_MAX)
    else $error("pre-scale or multiply count out of range");
  up_cause_a: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    (ref_rise && pre_cnt_q == n_eff - 11'h001 && !fb_evt) |=> o_osc_up)
    else $error("missing up pulse after pre-scale wrap");
  up_single_a: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    o_osc_up |=> !o_osc_up)
    else $error("up pulse longer than one cycle");
  dn_cause_a: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    o_osc_dn |-> $past(fb_evt) && !$past(ref_evt))
    else $error("down pulse without multiply wrap");
  no_both_a: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    !(o_osc_up && o_osc_dn))
    else $error("up and down pulses together");
  switch_time_a: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    $rose(o_ref_on_secondary) |->
      $past(loss_cnt_q) == LOSS_W'(LOSS_LIMIT - 1))
    else $error("switchover at wrong loss count");
  stay_pri_a: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    pri_rise |=> !$rose(o_ref_on_secondary))
    else $error("switched while primary toggles");
  sec_hold_a: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    o_ref_on_secondary |=> o_ref_on_secondary)
    else $error("reference fell back to primary");
  pin_select_a: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    !i_ext_user_mode |=> o_external_clock_output[0] ==
      ($past(post_clk[EXT_BASE + int'(i_ext_sel[0])])
       ^ $past(i_ext_invert[0])))
    else $error("external pin not from selected counter");
  user_pin_a: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    i_ext_user_mode |=> o_external_clock_output == $past(i_ext_user_data))
    else $error("external pin not showing user data");
endmodule : pcs_synth_ctrl
`default_nettype wire

//--- rtl/pcs_pkg.sv
// Purpose: shared constants for the clock synthesis control block
// Assumes: one 125 MHz clock that stands in for the oscillator
// Notes: post-scale index order is regional, global, external
package pcs_pkg;
  // clock period and loss-of-reference detection time
  localparam int CLK_PERIOD_PS = 8000;
  localparam int LOSS_TIME_NS = 1000;
  // a least time, so round the cycle count up
  localparam int LOSS_CYCLES =
    (LOSS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOSS_W = $clog2(LOSS_CYCLES + 1);

  // pre-scale and multiply counters, 1 to 512
  localparam int NM_W = 10;
  localparam logic [10:0] NM_MAX = 11'h200;
  // post-scale counters, 1 to 1024 at 50 %, 1 to 512 otherwise
  localparam int POST_W = 11;
  localparam logic [10:0] POST_MAX_50 = 11'h400;
  localparam logic [10:0] POST_MAX_ANY = 11'h200;

  // post-scale counter population
  localparam int NUM_REGIONAL = 2;
  localparam int NUM_GLOBAL = 4;
  localparam int NUM_EXTERNAL = 4;
  localparam int NUM_POST = NUM_REGIONAL + NUM_GLOBAL + NUM_EXTERNAL;
  localparam int GLOBAL_BASE = NUM_REGIONAL;
  localparam int EXT_BASE = NUM_REGIONAL + NUM_GLOBAL;
  localparam int EXT_SEL_W = 2;

  // external clock output pins of one pair
  localparam int NUM_EXT_PINS = 2;

  // forces a divide value into 1..max
  function automatic logic [10:0] pcs_sat(input logic [10:0] val,
                                          input logic [10:0] max);
    if (val == 11'h000)
      return 11'h001;
    else if (val > max)
      return max;
    else
      return val;
  endfunction : pcs_sat
endpackage : pcs_pkg

//--- rtl/pcs_post_div.sv
// Purpose: one post-scale divider with selectable duty cycle
// Assumes: divide settings change only while the output is unused
// Notes: divide by 1 holds the output high (every cycle active)
`timescale 1ns/1ps
`default_nettype none
module pcs_post_div
  import pcs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [pcs_pkg::POST_W-1:0] i_div,
  input wire logic i_duty50,
  input wire logic [pcs_pkg::POST_W-1:0] i_high,
  output logic o_clk
);
  logic [POST_W-1:0] div_eff;
  logic [POST_W-1:0] high_eff;
  logic [POST_W-1:0] cnt_q;
  logic [POST_W-1:0] cnt_d;
  logic out_q;

  // range depends on duty mode; non-50 % settings lose the top half
  always_comb
  begin
    div_eff = pcs_sat(i_div, i_duty50 ? POST_MAX_50 : POST_MAX_ANY);
    if (i_duty50)
      high_eff = div_eff - (div_eff >> 1);
    else if (i_high == 11'h000)
      high_eff = 11'h001;
    else if (i_high >= div_eff)
      high_eff = (div_eff == 11'h001) ? 11'h001 : div_eff - 11'h001;
    else
      high_eff = i_high;
    cnt_d = (cnt_q >= div_eff - 11'h001) ? 11'h000 : cnt_q + 11'h001;
  end

  // free-running count of oscillator cycles
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      cnt_q <= 11'h000;
    else
      cnt_q <= cnt_d;
  end

  // output registered so the port comes straight from a flop; it compares
  // the present count, so the first period after reset is a whole one
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      out_q <= 1'b0;
    else
      out_q <= (cnt_q < high_eff);
  end

  assign o_clk = out_q;

  cnt_range_a: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    cnt_q < div_eff)
    else $error("post-scale count beyond divide value");
  div_limit_a: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    (div_eff >= 11'h001) && (i_duty50 || div_eff <= POST_MAX_ANY))
    else $error("post-scale divide value outside range");
  half_high_a: assert property (@(posedge i_ref_clk)
    disable iff (i_rst)
    (i_duty50 && $stable(i_div) && div_eff == 11'h004 && $rose(out_q))
    |=> out_q ##1 !out_q ##1 !out_q ##1 out_q)
    else $error("50 percent waveform not split evenly");
endmodule : pcs_post_div
`default_nettype wire

//--- testbench/pcs_ref_model.sv
// Purpose: reference and feedback clock sources for the synthesizer
// Assumes: an enabled source toggles on every rising clock edge
// Notes: a stopped source parks low, so no stray edge is seen
`timescale 1ns/1ps
`default_nettype none
module pcs_ref_model
(
  input wire logic i_ref_clk,
  input wire logic i_pri_en,
  input wire logic i_sec_en,
  input wire logic i_fb_en,
  output logic o_pri,
  output logic o_sec,
  output logic o_fb
);
  // start low so the first toggle is a clean rising edge
  initial
  begin
    o_pri = 1'h0;
    o_sec = 1'h0;
    o_fb = 1'h0;
  end
  // changes land just after the edge, like the bench's own drives
  always @(posedge i_ref_clk)
  begin
    o_pri <= #1 i_pri_en & ~o_pri;
    o_sec <= #1 i_sec_en & ~o_sec;
    o_fb <= #1 i_fb_en & ~o_fb;
  end
endmodule : pcs_ref_model
`default_nettype wire

//--- testbench/tb.sv
// Purpose: self-checking bench for the clock synthesis control block
// Assumes: settings change only under reset, as the block requires
// Notes: loss limit is shortened to keep switchover runs brief
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pcs_pkg::*;
  localparam int LL = 8;
  logic i_ref_clk = 1'h0;
  logic i_rst = 1'h1;
  logic [NUM_POST-1:0][POST_W-1:0] div = '0;
  logic [NUM_POST-1:0][POST_W-1:0] high = '0;
  logic [NUM_POST-1:0] d50 = '0;
  logic [1:0][1:0] sel = '0;
  logic [1:0] inv = '0;
  logic [1:0] udat = '0;
  logic umode = 1'h0;
  logic pe = 1'h0;
  logic se = 1'h0;
  logic fe = 1'h0;
  logic [9:0] n = 10'h001;
  logic [9:0] m = 10'h001;
  logic up, dn, sec, pri, sr, fb, armed, pexp;
  logic [1:0] rg, pins;
  logic [3:0] gl, ec, pv;
  logic [9:0] pc;
  int err_count = 0;
  int tests_run = 0;
  int seed = 26;
  int nu, nd, d, w, ne, me, hx;
  int cnt [NUM_POST];
  int corner [7] = '{1, 1100, 700, 3, 0, 2, 4};

  assign pc = {ec, gl, rg};
  // oscillator stand-in
  always #4 i_ref_clk = ~i_ref_clk;

  pcs_ref_model src (.i_ref_clk(i_ref_clk), .i_pri_en(pe),
    .i_sec_en(se), .i_fb_en(fe), .o_pri(pri), .o_sec(sr), .o_fb(fb));

  pcs_synth_ctrl #(.LOSS_LIMIT(LL)) DUT (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_reference_clock_input_pri(pri),
    .i_reference_clock_input_sec(sr), .i_feedback_clock_input(fb),
    .i_pre_div(n), .i_mult(m), .i_post_div(div), .i_post_duty50(d50),
    .i_post_high(high), .i_ext_sel(sel), .i_ext_invert(inv),
    .i_ext_user_mode(umode), .i_ext_user_data(udat), .o_osc_up(up),
    .o_osc_dn(dn), .o_ref_on_secondary(sec), .o_regional_clk(rg),
    .o_global_clk(gl), .o_ext_cnt_clk(ec), .o_external_clock_output(pins));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("counts: %0d checks, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // divide value the block really uses after clamping
  function automatic int eff(input int dv, input logic f);
    int mx;
    mx = f ? 1024 : 512;
    return (dv == 0) ? 1 : (dv > mx) ? mx : dv;
  endfunction : eff

  // high cycles in one output period
  function automatic int exp_hi(input int dv, input logic f, input int h);
    int e;
    e = eff(dv, f);
    if (f)
      return e - e / 2;
    if (e == 1 || h == 0)
      return 1;
    return (h >= e) ? e - 1 : h;
  endfunction : exp_hi

  task automatic rst();
    i_rst = 1'h1;
    armed = 1'h0;
    repeat (8) @(posedge i_ref_clk);
    #1 i_rst = 1'h0;
    nu = 0;
    nd = 0;
    foreach (cnt[k]) cnt[k] = 0;
  endtask : rst

  // clocks c cycles, tallying pulses and highs, checking pins each cycle after the first since reset
  task automatic run(input int c);
    repeat (c)
    begin
      pv = ec;
      @(posedge i_ref_clk);
      #1;
      nu += up;
      nd += dn;
      foreach (cnt[k]) cnt[k] += pc[k];
      for (int k = 0; k < 2; k++)
      begin
        pexp = umode ? udat[k] : pv[sel[k]] ^ inv[k];
        if (armed)
          check("pin", pins[k], pexp);
      end
      armed = 1'h1;
    end
  endtask : run

  // hang guard: a stall here counts as a mismatch
  initial
  begin
    #400000;
    err_count++;
    give_verdict();
  end

  initial
  begin
    // post-scale shapes; corners cover 1, clamps and zero
    for (int t = 0; t < 15; t++)
    begin
      d = (t < 7) ? corner[t] : 1 + $unsigned($random(seed)) % 40;
      for (int k = 0; k < NUM_POST; k++)
      begin
        div[k] = POST_W'(d);
        d50[k] = (d > 512) ? t[0] : 1'($random(seed));
        high[k] = POST_W'($unsigned($random(seed)) % (d + 2));
      end
      umode = 1'($random(seed));
      udat = 2'($random(seed));
      sel = 4'($random(seed));
      inv = 2'($random(seed));
      w = 2 * eff(d, d50[0]);
      rst();
      run(w);
      foreach (cnt[k])
      begin
        hx = exp_hi(d, d50[k], high[k]) * w / eff(d, d50[k]);
        check("high count", cnt[k], hx);
      end
    end
    $display("post-scale and pin test done");
    // pre-scale, multiply and switchover; zero means one
    for (int t = 0; t < 3; t++)
    begin
      n = (t == 0) ? 10'h000 : 10'(1 + $unsigned($random(seed)) % 5);
      m = (t == 1) ? 10'h000 : 10'(1 + $unsigned($random(seed)) % 5);
      ne = (n == 0) ? 1 : int'(n);
      me = (m == 0) ? 1 : int'(m);
      rst();
      pe = 1'h1;
      run(6 * ne);
      pe = 1'h0;
      run(3);
      check("up pulses", nu, 3);
      check("dn pulses", nd, 0);
      check("on secondary", sec, 1'h0);
      fe = 1'h1;
      run(6 * me);
      fe = 1'h0;
      run(LL + 4);
      check("dn pulses", nd, 3);
      check("on secondary", sec, 1'h1);
      nu = 0;
      se = 1'h1;
      run(4 * ne);
      se = 1'h0;
      pe = 1'h1;
      run(4);
      pe = 1'h0;
      check("secondary up pulses", nu, 2);
      check("stays secondary", sec, 1'h1);
    end
    $display("divider and switchover test done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
